/* hw/two_wire_pkg.sv */
// Contract
// R1: after acknowledged broadcast data report 0x90; next byte acked per ack enable.
// R2: after not-acked broadcast data report 0x98, then leave to not addressed.
// R3: STOP or repeated START while addressed reports 0xA0.
// R4: not addressed: ack enable gates own address; broadcast also needs accept bit.
// R5: begin request on release of 0x98/0xA0 gives START once bus is free.
// R6: software masks prescaler bits before comparing status codes.
// R7: answer seven-bit own address; broadcast 0x00 only when address bit 0 set.
// R8: software sets enable and ack enable, clears begin, halt, done, collision; a control write leaves collision as is.
// R9: direction bit one selects transmit, zero selects receive.
// R10: after own address and direction, set done flag with valid status.
// R11: lost arbitration then addressed for read enters transmit, reports 0xB0.
// R12: ack enable cleared in transmit: last byte, then 0xC0 on nack, 0xC8 on ack.
// R13: after last byte go not addressed and ignore clocks; master reads ones.
// R14: master ack of final byte reports 0xC8; master should end with nack.
// R15: ack enable zero ignores own address but keeps watching the bus.
// R16: in clock-stopping sleep still acknowledge address match and wake the part.
// R17: after wake-up hold SCL low until done flag cleared by writing one.
// R18: data register content is not defined after wake from clock-stopping sleep.
// R19: own address with read acked reports 0xA8 and sends loaded byte.
// R20: transmitted byte acked reports 0xB8; next byte is last if ack enable zero.
package two_wire_pkg;
	localparam int        ADDR_W       = 2;
	localparam [1:0]      OFS_DATA     = 2'h0;
	localparam [1:0]      OFS_STATUS   = 2'h1;
	localparam [1:0]      OFS_OWN      = 2'h2;
	localparam [1:0]      OFS_CTRL     = 2'h3;
	localparam int        CTL_DONE     = 7;
	localparam int        CTL_ACK      = 6;
	localparam int        CTL_BEGIN    = 5;
	localparam int        CTL_HALT     = 4;
	localparam int        CTL_WCOL     = 3;
	localparam int        CTL_EN       = 2;
	localparam int        CTL_IRQ      = 0;
	localparam int        OWN_GCE      = 0;
	localparam [7:0]      DATA_RST     = 8'hFF;
	localparam [7:0]      OWN_RST      = 8'h00;
	localparam [7:0]      CTRL_RST     = 8'h00;
	localparam [7:0]      ST_NONE      = 8'hF8;
	localparam [7:0]      ST_SR_OWN    = 8'h60;
	localparam [7:0]      ST_SR_ARB    = 8'h68;
	localparam [7:0]      ST_SR_GC     = 8'h70;
	localparam [7:0]      ST_SR_GC_ARB = 8'h78;
	localparam [7:0]      ST_SR_ACK    = 8'h80;
	localparam [7:0]      ST_SR_NACK   = 8'h88;
	localparam [7:0]      ST_GC_ACK    = 8'h90;
	localparam [7:0]      ST_GC_NACK   = 8'h98;
	localparam [7:0]      ST_STOP      = 8'hA0;
	localparam [7:0]      ST_ST_OWN    = 8'hA8;
	localparam [7:0]      ST_ST_ARB    = 8'hB0;
	localparam [7:0]      ST_ST_ACK    = 8'hB8;
	localparam [7:0]      ST_ST_NACK   = 8'hC0;
	localparam [7:0]      ST_ST_LAST   = 8'hC8;
	localparam [6:0]      GC_ADDR      = 7'h00;
	localparam [3:0]      BYTE_BITS    = 4'h8;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_AACK = 3'b011,
		S_HOLD = 3'b010,
		S_TX   = 3'b110,
		S_TACK = 3'b111,
		S_RX   = 3'b101,
		S_RACK = 3'b100
	} state_t;

	typedef enum logic [1:0] {
		NX_NA = 2'b00,
		NX_TX = 2'b01,
		NX_RX = 2'b10
	} after_t;

	typedef struct packed {
		state_t     state;
		after_t     nxt;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] data;
		logic [7:0] own;
		logic [7:0] ctrl;
		logic [7:0] code;
		logic [7:0] rdata;
		logic [1:0] presc;
		logic       rw;
		logic       gc;
		logic       last;
		logic       ackd;
		logic       ack_nx;
		logic       sda_drv;
		logic       wake;
		logic       start_pend;
		logic       busy;
		logic       start_req;
		logic       scl_oe_n;
		logic       sda_oe_n;
		logic       pin_lo;
		logic       scl_m;
		logic       scl_s;
		logic       scl_p;
		logic       sda_m;
		logic       sda_s;
		logic       sda_p;
	} core_t;
endpackage : two_wire_pkg

/* hw/two_wire_slave_rx_tx.sv */
`timescale 1ns/1ps
module two_wire_slave_rx_tx (
	input  wire logic                           ref_clk_i,
	input  wire logic                           rstn_i,
	input  wire logic [two_wire_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [7:0]                     reg_wdata_i,
	input  wire logic                           reg_wr_i,
	input  wire logic                           reg_rd_i,
	output logic      [7:0]                     reg_rdata_o,
	input  wire logic                           scl_i,
	output logic                                scl_o,
	output logic                                scl_oe_n_o,
	input  wire logic                           sda_i,
	output logic                                sda_o,
	output logic                                sda_oe_n_o,
	input  wire logic                           sleep_i,
	input  wire logic                           arb_lost_i,
	output logic                                wake_o,
	output logic                                start_req_o
);
	import two_wire_pkg::*;

	core_t q;
	core_t d;
	logic  rise;
	logic  fall;
	logic  start;
	logic  stop;
	logic  ack_on;
	logic  own_hit;
	logic  gc_hit;
	logic  match;
	logic  rel;
	logic  addressed;

	always_comb
	begin
		d = q;
		// second stage and its delayed copy feed the edge logic; the second SDA stage also feeds bit and ack sampling
		d.scl_m = scl_i;
		d.scl_s = q.scl_m;
		d.scl_p = q.scl_s;
		d.sda_m = sda_i;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		rise  = q.scl_s & ~q.scl_p;
		fall  = ~q.scl_s & q.scl_p;
		start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
		stop  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
		ack_on  = q.ctrl[CTL_ACK] & q.ctrl[CTL_EN];            // [R4] [R15]
		own_hit = q.sh[7:1] == q.own[7:1];                     // [R7]
		gc_hit  = (q.sh[7:1] == GC_ADDR) & q.own[OWN_GCE];     // [R7]
		// broadcast is write-only; a read under it is not answered
		match   = ack_on & (own_hit | (gc_hit & ~q.sh[0]));    // [R4] [R16]
		rel = q.ctrl[CTL_DONE] & reg_wr_i & (reg_addr_i == OFS_CTRL)
			& reg_wdata_i[CTL_DONE];
		addressed = (q.state == S_RX) | (q.state == S_RACK)
			| (q.state == S_TX) | (q.state == S_TACK);

		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				OFS_DATA:
				begin
					if (q.ctrl[CTL_DONE])
						d.data = reg_wdata_i;
					else
						d.ctrl[CTL_WCOL] = 1'b1;
				end
				OFS_STATUS: d.presc = reg_wdata_i[1:0];        // [R6]
				OFS_OWN:    d.own = reg_wdata_i;
				OFS_CTRL:
				begin
					if (reg_wdata_i[CTL_DONE])
						d.ctrl[CTL_DONE] = 1'b0;           // [R17]
					d.ctrl[CTL_ACK]   = reg_wdata_i[CTL_ACK];
					d.ctrl[CTL_BEGIN] = reg_wdata_i[CTL_BEGIN];
					d.ctrl[CTL_HALT]  = reg_wdata_i[CTL_HALT];
					d.ctrl[CTL_EN]    = reg_wdata_i[CTL_EN];
					d.ctrl[CTL_IRQ]   = reg_wdata_i[CTL_IRQ];
				end
			endcase
			if (reg_addr_i == OFS_DATA && q.ctrl[CTL_DONE])
				d.ctrl[CTL_WCOL] = 1'b0;
		end

		d.rdata = 8'h00;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				OFS_DATA:   d.rdata = q.data;                  // [R18]
				OFS_STATUS: d.rdata = {(q.ctrl[CTL_DONE] ? q.code[7:3]
					: ST_NONE[7:3]), 1'b0, q.presc};           // [R6] [R10]
				OFS_OWN:    d.rdata = q.own;
				OFS_CTRL:   d.rdata = q.ctrl;
			endcase
		end

		if (start)
			d.busy = 1'b1;
		else if (stop)
			d.busy = 1'b0;
		if (start)
			d.start_pend = 1'b0;

		// bus events come after the register writes so a set beats a clear
		if (!q.ctrl[CTL_EN])
		begin
			d.state   = S_IDLE;
			d.sda_drv = 1'b0;
			d.wake    = 1'b0;
		end
		else if ((start | stop) && addressed)
		begin
			d.code             = ST_STOP;                      // [R3]
			d.ctrl[CTL_DONE]   = 1'b1;
			d.nxt              = NX_NA;
			d.state            = S_HOLD;
			d.sda_drv          = 1'b0;
		end
		else if ((start | stop) && q.state != S_HOLD)
		begin
			d.state   = start ? S_ADDR : S_IDLE;
			d.cnt     = 4'h0;
			d.sda_drv = 1'b0;
		end
		else
		begin
			unique case (q.state)
				S_IDLE: ;                                  // [R13]
				S_ADDR:
				begin
					if (rise)
					begin
						d.sh  = {q.sh[6:0], q.sda_s};
						d.cnt = q.cnt + 4'h1;
					end
					if (fall && q.cnt == BYTE_BITS)
					begin
						if (match)
						begin
							d.sda_drv = 1'b1;
							d.rw      = q.sh[0];           // [R9]
							d.gc      = ~own_hit;
							d.state   = S_AACK;
						end
						else
							d.state = S_IDLE;          // [R15]
					end
				end
				S_AACK:
				begin
					if (fall)
					begin
						d.sda_drv        = 1'b0;
						d.ctrl[CTL_DONE] = 1'b1;           // [R10]
						d.wake           = sleep_i;        // [R16]
						d.state          = S_HOLD;         // [R17]
						d.cnt            = 4'h0;
						if (q.rw)
						begin
							d.nxt  = NX_TX;
							d.code = arb_lost_i ? ST_ST_ARB   // [R11]
								: ST_ST_OWN;               // [R19]
						end
						else
						begin
							d.nxt = NX_RX;
							if (q.gc)
								d.code = arb_lost_i ? ST_SR_GC_ARB
									: ST_SR_GC;
							else
								d.code = arb_lost_i ? ST_SR_ARB
									: ST_SR_OWN;
						end
					end
				end
				S_HOLD:
				begin
					if (rel)
					begin
						d.wake = 1'b0;
						d.cnt  = 4'h0;
						unique case (q.nxt)
							NX_TX:
							begin
								d.sh      = q.data;        // [R19]
								d.sda_drv = ~q.data[7];
								d.last    = ~reg_wdata_i[CTL_ACK]; // [R12] [R20]
								d.state   = S_TX;
							end
							NX_RX:
							begin
								d.ack_nx = reg_wdata_i[CTL_ACK];   // [R1]
								d.state  = S_RX;
							end
							NX_NA:
							begin
								d.state = S_IDLE;          // [R2] [R13]
								if (reg_wdata_i[CTL_BEGIN])
									d.start_pend = 1'b1;   // [R5]
							end
						endcase
					end
				end
				S_TX:
				begin
					if (rise)
						d.cnt = q.cnt + 4'h1;
					if (fall)
					begin
						if (q.cnt == BYTE_BITS)
						begin
							d.sda_drv = 1'b0;
							d.state   = S_TACK;
						end
						else
						begin
							d.sda_drv = ~q.sh[6];
							d.sh      = {q.sh[6:0], 1'b0};
						end
					end
				end
				S_TACK:
				begin
					if (rise)
						d.ackd = ~q.sda_s;
					if (fall)
					begin
						d.ctrl[CTL_DONE] = 1'b1;
						d.state          = S_HOLD;
						d.cnt            = 4'h0;
						if (!q.ackd)
							d.code = ST_ST_NACK;           // [R12]
						else if (q.last)
							d.code = ST_ST_LAST;           // [R12] [R14]
						else
							d.code = ST_ST_ACK;            // [R20]
						d.nxt = (q.ackd & ~q.last) ? NX_TX : NX_NA; // [R13]
					end
				end
				S_RX:
				begin
					if (rise)
					begin
						d.sh  = {q.sh[6:0], q.sda_s};
						d.cnt = q.cnt + 4'h1;
					end
					if (fall && q.cnt == BYTE_BITS)
					begin
						d.sda_drv = q.ack_nx;              // [R1]
						d.state   = S_RACK;
					end
				end
				S_RACK:
				begin
					if (fall)
					begin
						d.sda_drv = 1'b0;
						// byte dropped while asleep; content is undefined then
						if (!sleep_i)
							d.data = q.sh;                 // [R18]
						d.ctrl[CTL_DONE] = 1'b1;
						d.state          = S_HOLD;
						d.cnt            = 4'h0;
						d.nxt            = q.ack_nx ? NX_RX : NX_NA;
						if (q.gc)
							d.code = q.ack_nx ? ST_GC_ACK  // [R1]
								: ST_GC_NACK;              // [R2]
						else
							d.code = q.ack_nx ? ST_SR_ACK : ST_SR_NACK;
					end
				end
			endcase
		end

		// stretch only while the done flag stands, so a release frees SCL
		d.scl_oe_n  = ~((d.state == S_HOLD) & d.ctrl[CTL_DONE]); // [R17]
		d.sda_oe_n  = ~d.sda_drv;
		d.start_req = d.start_pend & ~d.busy;                  // [R5]
		d.pin_lo    = 1'b0;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			q            <= '0;
			q.state      <= S_IDLE;
			q.nxt        <= NX_NA;
			q.data       <= DATA_RST;
			q.own        <= OWN_RST;
			q.ctrl       <= CTRL_RST;
			q.code       <= ST_NONE;
			q.scl_oe_n   <= 1'b1;
			q.sda_oe_n   <= 1'b1;
			q.scl_m      <= 1'b1;
			q.scl_s      <= 1'b1;
			q.scl_p      <= 1'b1;
			q.sda_m      <= 1'b1;
			q.sda_s      <= 1'b1;
			q.sda_p      <= 1'b1;
		end
		else
			q <= d;
	end

	assign reg_rdata_o = q.rdata;
	assign scl_o       = q.pin_lo;
	assign scl_oe_n_o  = q.scl_oe_n;
	assign sda_o       = q.pin_lo;
	assign sda_oe_n_o  = q.sda_oe_n;
	assign wake_o      = q.wake;
	assign start_req_o = q.start_req;
endmodule : two_wire_slave_rx_tx

/* dv/two_wire_slave_rx_tx_asserts.sv */
`timescale 1ns/1ps
module two_wire_slave_rx_tx_asserts (
	input wire logic                              ref_clk_i,
	input wire logic                              rstn_i,
	input wire logic [two_wire_pkg::ADDR_W-1:0]   reg_addr_i,
	input wire logic [7:0]                        reg_wdata_i,
	input wire logic                              reg_wr_i,
	input wire logic                              reg_rd_i,
	input wire logic [7:0]                        reg_rdata_o,
	input wire logic                              scl_i,
	input wire logic                              sda_i,
	input wire logic                              scl_oe_n_o,
	input wire logic                              sda_oe_n_o,
	input wire logic                              sleep_i,
	input wire logic                              wake_o,
	input wire logic                              start_req_o
);
	import two_wire_pkg::*;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	logic rel;
	assign rel = reg_wr_i && reg_addr_i == OFS_CTRL && reg_wdata_i[CTL_DONE];
	sequence own_wr;
		reg_wr_i && reg_addr_i == OFS_OWN;
	endsequence
	sequence own_rd;
		reg_rd_i && reg_addr_i == OFS_OWN;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_own_echo: assert property (own_wr ##2 own_rd |=>
		reg_rdata_o == $past(reg_wdata_i, 3)) else $error("own address lost");
	a_idle_status: assert property (reg_rd_i && reg_addr_i == OFS_STATUS
		&& scl_oe_n_o |=> reg_rdata_o == ST_NONE) else $error("status not idle");
	a_stretch_hold: assert property (!scl_oe_n_o && !rel |=> !scl_oe_n_o)
		else $error("clock stretch ended early");
	a_scl_release: assert property (!scl_oe_n_o && rel |=> scl_oe_n_o)
		else $error("clock not released");
	a_wake_sleep: assert property ($rose(wake_o) |->
		sleep_i ##[0:40] !scl_oe_n_o) else $error("bad wake");
	a_sda_quiet: assert property ($changed(sda_oe_n_o) |-> !scl_i)
		else $error("data moved while clock high");
	a_start_free: assert property ($rose(start_req_o) |-> scl_i && sda_i)
		else $error("start asked on busy bus");
endmodule : two_wire_slave_rx_tx_asserts
bind two_wire_slave_rx_tx two_wire_slave_rx_tx_asserts u_chk (
	.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .scl_i, .sda_i, .scl_oe_n_o, .sda_oe_n_o, .sleep_i,
	.wake_o, .start_req_o
);

/* dv/two_wire_master_model.sv */
`timescale 1ns/1ps
module two_wire_master_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	localparam realtime Q = 31.25;
	initial
	begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end
	// waits out a slave stretch before the high phase counts
	task automatic bit_x(input logic b, output logic r);
		sda_o = b;
		#Q scl_o = 1'h1;
		wait (scl_i);
		#Q r = sda_i;
		#Q scl_o = 1'h0;
		#Q;
	endtask : bit_x
	task automatic start_c();
		sda_o = 1'h1;
		#Q scl_o = 1'h1;
		#Q sda_o = 1'h0;
		#Q scl_o = 1'h0;
		#Q;
	endtask : start_c
	task automatic stop_c();
		sda_o = 1'h0;
		#Q scl_o = 1'h1;
		#Q sda_o = 1'h1;
		#Q;
	endtask : stop_c
	// msb first, ninth clock is the ack; nack ends a read
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(a, k);
	endtask : xfer
endmodule : two_wire_master_model

/* dv/two_wire_slave_rx_tx_bench.sv */
`timescale 1ns/1ps
module two_wire_slave_rx_tx_bench;
	import two_wire_pkg::*;
	logic              ref_clk_i, rstn_i, reg_wr_i, reg_rd_i, sleep_i;
	logic              arb_lost_i, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
	logic              wake_o, start_req_o, m_scl, m_sda, scl_w, sda_w, rd_q;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [7:0]        reg_wdata_i, reg_rdata_o, d;
	logic [7:0]        exp_q[$];
	integer            seed, fail_count, total_checks, cyc;
	assign scl_w = m_scl & (scl_oe_n_o | scl_o);
	assign sda_w = m_sda & (sda_oe_n_o | sda_o);
	two_wire_slave_rx_tx uut (.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .scl_i(scl_w), .scl_o, .scl_oe_n_o,
		.sda_i(sda_w), .sda_o, .sda_oe_n_o, .sleep_i, .arb_lost_i, .wake_o,
		.start_req_o);
	two_wire_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl),
		.sda_o(m_sda));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'h1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'h1;
		exp_q.push_back(e);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h0;
	endtask : rd
	// slack lets the stretch and status land before software looks
	task automatic mx(input logic [7:0] v, input logic a,
		input logic [7:0] e, input logic ea);
		logic [7:0] q;
		logic       k;
		m.xfer(v, a, q, k);
		repeat (4) @(posedge ref_clk_i);
		chk("bus byte", q, e);
		chk("bus ack", {7'h00, k}, {7'h00, ea});
	endtask : mx
	initial
	begin
		ref_clk_i = 1'h0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i)
	begin
		if (rd_q)
			chk("register read", reg_rdata_o, exp_q.pop_front());
		rd_q <= reg_rd_i;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	initial
	begin
		{rstn_i, reg_wr_i, reg_rd_i, sleep_i, arb_lost_i, rd_q} = 6'h00;
		reg_addr_i = OFS_DATA;
		reg_wdata_i = 8'h00;
		seed = 71080;
		fail_count = 0;
		total_checks = 0;
		cyc = 0;
		repeat (4) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		repeat (4) @(posedge ref_clk_i);
		rd(OFS_STATUS, ST_NONE);
		// data write with no pending byte is refused and flags a collision
		wr(OFS_DATA, 8'h12);
		rd(OFS_CTRL, 8'(1 << CTL_WCOL));
		rd(OFS_DATA, DATA_RST);
		wr(OFS_OWN, 8'h55);
		rd(OFS_OWN, 8'h55);
		// prescaler stays zero so codes compare whole
		wr(OFS_CTRL, 8'h44);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge ref_clk_i);
			arb_lost_i <= i[0];
			m.start_c();
			mx(8'h55, 1'h1, 8'h55, 1'h0);
			rd(OFS_STATUS, i ? ST_ST_ARB : ST_ST_OWN);
			arb_lost_i <= 1'h0;
			d = 8'($random(seed));
			wr(OFS_DATA, d);
			wr(OFS_CTRL, 8'hC4);
			mx(8'hFF, 1'h0, d, 1'h0);
			rd(OFS_STATUS, ST_ST_ACK);
			d = 8'($random(seed));
			wr(OFS_DATA, d);
			wr(OFS_CTRL, 8'h84);
			mx(8'hFF, i[0], d, i[0]);
			rd(OFS_STATUS, i ? ST_ST_NACK : ST_ST_LAST);
			wr(OFS_CTRL, 8'hC4);
			mx(8'hFF, 1'h1, 8'hFF, 1'h1);
			m.stop_c();
		end
		m.start_c();
		mx(8'h00, 1'h1, 8'h00, 1'h0);
		rd(OFS_STATUS, ST_SR_GC);
		wr(OFS_CTRL, 8'hC4);
		d = 8'($random(seed));
		mx(d, 1'h1, d, 1'h0);
		rd(OFS_STATUS, ST_GC_ACK);
		rd(OFS_DATA, d);
		wr(OFS_CTRL, 8'h84);
		mx(d, 1'h1, d, 1'h1);
		rd(OFS_STATUS, ST_GC_NACK);
		wr(OFS_CTRL, 8'hA4);
		m.stop_c();
		repeat (8) @(negedge ref_clk_i);
		chk("start request", {7'h00, start_req_o}, 8'h01);
		m.start_c();
		mx(8'h54, 1'h1, 8'h54, 1'h1);
		m.stop_c();
		wr(OFS_CTRL, 8'h44);
		wr(OFS_OWN, 8'h54);
		m.start_c();
		mx(8'h00, 1'h1, 8'h00, 1'h1);
		m.stop_c();
		m.start_c();
		mx(8'h54, 1'h1, 8'h54, 1'h0);
		rd(OFS_STATUS, ST_SR_OWN);
		wr(OFS_CTRL, 8'hC4);
		d = 8'($random(seed));
		mx(d, 1'h1, d, 1'h0);
		rd(OFS_STATUS, ST_SR_ACK);
		rd(OFS_DATA, d);
		wr(OFS_CTRL, 8'hC4);
		m.start_c();
		repeat (8) @(posedge ref_clk_i);
		rd(OFS_STATUS, ST_STOP);
		wr(OFS_CTRL, 8'hC4);
		m.stop_c();
		@(posedge ref_clk_i);
		sleep_i <= 1'h1;
		m.start_c();
		mx(8'h54, 1'h1, 8'h54, 1'h0);
		@(negedge ref_clk_i);
		chk("wake", {6'h00, wake_o, scl_oe_n_o}, 8'h02);
		rd(OFS_STATUS, ST_SR_OWN);
		sleep_i <= 1'h0;
		wr(OFS_CTRL, 8'hC4);
		@(negedge ref_clk_i);
		chk("wake", {6'h00, wake_o, scl_oe_n_o}, 8'h01);
		m.stop_c();
		repeat (3) @(posedge ref_clk_i);
		give_verdict();
	end
endmodule : two_wire_slave_rx_tx_bench
